// file: common/dtset_pkg.sv
// Constants and types shared by the timer set
package dtset_pkg;
   localparam int unsigned TMR_W      = 32;
   localparam int unsigned CFG_W      = 6;
   localparam int unsigned NUM_GPT    = 3;
   // Configuration field layout
   localparam int unsigned CFG_MODE_LO = 0;
   localparam int unsigned CFG_MODE_HI = 1;
   localparam int unsigned CFG_PULSE_HI_BIT = 2;
   localparam int unsigned CFG_IRQ_EN_BIT   = 3;
   localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;
   localparam logic [TMR_W-1:0] CNT_ZERO  = 32'h00000000;
   localparam logic [TMR_W-1:0] CNT_ONE   = 32'h00000001;
   localparam logic [TMR_W-1:0] CNT_MAX   = 32'hFFFFFFFF;

   // Gray codes along the usual path
   typedef enum logic [1:0] {
      DTSET_MODE_OFF  = 2'h0,
      DTSET_MODE_PWM  = 2'h1,
      DTSET_MODE_WDTH = 2'h3,
      DTSET_MODE_WDOG = 2'h2
   } dtset_mode_t;
endpackage : dtset_pkg

// file: logic/dtset_gp_timer.sv
// One general-purpose timer channel
`timescale 1ns/1ps
`default_nettype none
module dtset_gp_timer (
   input  wire logic                       ref_clk_in,
   input  wire logic                       rst_n_in,
   input  wire logic                       enable_in,
   input  wire logic [dtset_pkg::CFG_W-1:0] config_in,
   input  wire logic [dtset_pkg::TMR_W-1:0] period_in,
   input  wire logic [dtset_pkg::TMR_W-1:0] width_in,
   input  wire logic                       pin_sync_in,
   output logic [dtset_pkg::TMR_W-1:0]      count_out,
   output logic [dtset_pkg::TMR_W-1:0]      cap_period_out,
   output logic [dtset_pkg::TMR_W-1:0]      cap_width_out,
   output logic                            pin_out,
   output logic                            pin_oe_out,
   output logic                            irq_out,
   output logic                            overflow_out
);
   import dtset_pkg::*;

   dtset_mode_t      mode;
   logic [TMR_W-1:0] cnt_q, cnt_d, per_q, per_d, wid_q, wid_d;
   logic             pin_q, pin_d, oe_q, oe_d, irq_q, irq_d;
   logic             ovf_q, ovf_d, prev_q, prev_d;
   logic             act_lvl, rise, fall;

   assign mode    = dtset_mode_t'(config_in[CFG_MODE_HI:CFG_MODE_LO]);
   assign act_lvl = config_in[CFG_PULSE_HI_BIT];
   assign rise    = pin_sync_in & ~prev_q;
   assign fall    = ~pin_sync_in & prev_q;

   // ---------------------------------------------------------------
   // Mode engine
   // ---------------------------------------------------------------
   always_comb begin
      cnt_d  = cnt_q;
      per_d  = per_q;
      wid_d  = wid_q;
      pin_d  = ~act_lvl;
      oe_d   = 1'b0;
      irq_d  = 1'b0;
      ovf_d  = 1'b0;
      prev_d = pin_sync_in;
      if (!enable_in) begin
         cnt_d = CNT_ZERO;
      end else begin
         case (mode)
            DTSET_MODE_PWM: begin
               // Pin drives out only in waveform mode
               oe_d = 1'b1;
               if (cnt_q + CNT_ONE >= period_in) begin
                  cnt_d = CNT_ZERO;
                  irq_d = config_in[CFG_IRQ_EN_BIT];
               end else begin
                  cnt_d = cnt_q + CNT_ONE;
               end
               pin_d = (cnt_d < width_in) ? act_lvl : ~act_lvl;
            end
            DTSET_MODE_WDTH: begin
               cnt_d = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + CNT_ONE;
               ovf_d = (cnt_q == CNT_MAX);
               if ((pin_sync_in == act_lvl) && (rise || fall)) begin
                  // Leading edge closes a period and starts the next
                  per_d = cnt_q;
                  cnt_d = CNT_ONE;
                  irq_d = config_in[CFG_IRQ_EN_BIT];
               end else if (rise || fall) begin
                  wid_d = cnt_q;
               end
            end
            DTSET_MODE_WDOG: begin
               // Counts rising pin edges; the edge that reaches the period restarts the count and raises the interrupt
               if (rise) begin
                  cnt_d = cnt_q + CNT_ONE;
               end
               if (cnt_d >= period_in && rise) begin
                  cnt_d = CNT_ZERO;
                  irq_d = config_in[CFG_IRQ_EN_BIT];
               end
            end
            default: begin
               cnt_d = CNT_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         cnt_q  <= CNT_ZERO;
         per_q  <= CNT_ZERO;
         wid_q  <= CNT_ZERO;
         pin_q  <= 1'b0;
         oe_q   <= 1'b0;
         irq_q  <= 1'b0;
         ovf_q  <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         per_q  <= per_d;
         wid_q  <= wid_d;
         pin_q  <= pin_d;
         oe_q   <= oe_d;
         irq_q  <= irq_d;
         ovf_q  <= ovf_d;
         prev_q <= prev_d;
      end
   end

   assign count_out      = cnt_q;
   assign cap_period_out = per_q;
   assign cap_width_out  = wid_q;
   assign pin_out        = pin_q;
   assign pin_oe_out     = oe_q;
   assign irq_out        = irq_q;
   assign overflow_out   = ovf_q;
endmodule : dtset_gp_timer
`default_nettype wire

// file: logic/dtset_top.sv
// Timer set: one core timer and three general-purpose timers
`timescale 1ns/1ps
`default_nettype none
module dtset_top #(
   parameter int unsigned NUM_GPT = dtset_pkg::NUM_GPT
) (
   input  wire logic                               ref_clk_in,
   input  wire logic                               rst_n_in,
   input  wire logic                               core_enable_in,
   input  wire logic                               core_pin_en_in,
   input  wire logic [dtset_pkg::TMR_W-1:0]         core_period_in,
   input  wire logic [NUM_GPT-1:0]                  gpt_enable_in,
   input  wire logic [NUM_GPT*dtset_pkg::CFG_W-1:0] gpt_config_in,
   input  wire logic [NUM_GPT*dtset_pkg::TMR_W-1:0] gpt_period_in,
   input  wire logic [NUM_GPT*dtset_pkg::TMR_W-1:0] gpt_width_in,
   input  wire logic [NUM_GPT-1:0]                  gpt_pin_in,
   output logic [dtset_pkg::TMR_W-1:0]              core_count_out,
   output logic                                     core_irq_out,
   output logic                                     core_timer_expiry_pin_out,
   output logic                                     core_timer_expiry_pin_oe_out,
   output logic [NUM_GPT*dtset_pkg::TMR_W-1:0]      gpt_count_out,
   output logic [NUM_GPT*dtset_pkg::TMR_W-1:0]      gpt_cap_period_out,
   output logic [NUM_GPT*dtset_pkg::TMR_W-1:0]      gpt_cap_width_out,
   output logic [NUM_GPT-1:0]                       gpt_status_out,
   output logic [NUM_GPT-1:0]                       gpt_overflow_out,
   output logic [NUM_GPT-1:0]                       gpt_pin_out,
   output logic [NUM_GPT-1:0]                       gpt_pin_oe_out,
   output logic [NUM_GPT-1:0]                       gpt_irq_out
);
   import dtset_pkg::*;

   // ---------------------------------------------------------------
   // Core timer
   // ---------------------------------------------------------------
   logic [TMR_W-1:0] ccnt_q, ccnt_d;
   logic             cirq_q, cirq_d, cpin_q, cpin_d, coe_q, coe_d;

   always_comb begin
      ccnt_d = ccnt_q;
      cirq_d = 1'b0;
      cpin_d = 1'b0;
      coe_d  = core_pin_en_in;
      if (!core_enable_in) begin
         ccnt_d = core_period_in;
      end else if (ccnt_q == CNT_ZERO) begin
         // Reload on expiry so the interrupt stays periodic
         ccnt_d = core_period_in;
         cirq_d = 1'b1;
         cpin_d = core_pin_en_in;
      end else begin
         ccnt_d = ccnt_q - CNT_ONE;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         ccnt_q <= CNT_ZERO;
         cirq_q <= 1'b0;
         cpin_q <= 1'b0;
         coe_q  <= 1'b0;
      end else begin
         ccnt_q <= ccnt_d;
         cirq_q <= cirq_d;
         cpin_q <= cpin_d;
         coe_q  <= coe_d;
      end
   end

   assign core_count_out               = ccnt_q;
   assign core_irq_out                 = cirq_q;
   assign core_timer_expiry_pin_out    = cpin_q;
   assign core_timer_expiry_pin_oe_out = coe_q;

   // ---------------------------------------------------------------
   // Shared enable word and pin synchronisers
   // ---------------------------------------------------------------
   logic [NUM_GPT-1:0] en_q, en_d, s1_q, s2_q;

   always_comb begin
      en_d = gpt_enable_in;
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         en_q <= '0;
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         en_q <= en_d;
         // Pins are asynchronous; two stages before any logic
         s1_q <= gpt_pin_in;
         s2_q <= s1_q;
      end
   end

   assign gpt_status_out = en_q;

   // ---------------------------------------------------------------
   // General-purpose timers
   // ---------------------------------------------------------------
   for (genvar g = 0; g < NUM_GPT; g++) begin : g_gpt
      dtset_gp_timer u_tmr (
         .ref_clk_in     (ref_clk_in),
         .rst_n_in       (rst_n_in),
         .enable_in      (en_q[g]),
         .config_in      (gpt_config_in[g*CFG_W +: CFG_W]),
         .period_in      (gpt_period_in[g*TMR_W +: TMR_W]),
         .width_in       (gpt_width_in[g*TMR_W +: TMR_W]),
         .pin_sync_in    (s2_q[g]),
         .count_out      (gpt_count_out[g*TMR_W +: TMR_W]),
         .cap_period_out (gpt_cap_period_out[g*TMR_W +: TMR_W]),
         .cap_width_out  (gpt_cap_width_out[g*TMR_W +: TMR_W]),
         .pin_out        (gpt_pin_out[g]),
         .pin_oe_out     (gpt_pin_oe_out[g]),
         .irq_out        (gpt_irq_out[g]),
         .overflow_out   (gpt_overflow_out[g])
      );
   end
endmodule : dtset_top
`default_nettype wire

// file: verif/dtset_top_properties.sv
// Port checker for the timer set
`timescale 1ns/1ps
`default_nettype none
module dtset_top_properties
   import dtset_pkg::*;
#(
   parameter int unsigned NUM_GPT = 3
) (
   input wire logic                       ref_clk_in,
   input wire logic                       rst_n_in,
   input wire logic                       core_pin_en_in,
   input wire logic [TMR_W-1:0]           core_period_in,
   input wire logic [NUM_GPT-1:0]         gpt_enable_in,
   input wire logic [NUM_GPT*CFG_W-1:0]   gpt_config_in,
   input wire logic [NUM_GPT*TMR_W-1:0]   gpt_period_in,
   input wire logic [NUM_GPT*TMR_W-1:0]   gpt_width_in,
   input wire logic                       core_irq_out,
   input wire logic                       core_timer_expiry_pin_oe_out,
   input wire logic [NUM_GPT*TMR_W-1:0]   gpt_count_out,
   input wire logic [NUM_GPT-1:0]         gpt_status_out,
   input wire logic [NUM_GPT-1:0]         gpt_pin_out,
   input wire logic [NUM_GPT-1:0]         gpt_pin_oe_out,
   input wire logic [NUM_GPT-1:0]         gpt_irq_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   // First interval after reset is not measured
   logic [TMR_W-1:0] gap_q;
   logic             seen_q;
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in || core_irq_out) begin
         gap_q <= CNT_ONE;
      end else begin
         gap_q <= gap_q + CNT_ONE;
      end
      seen_q <= rst_n_in && (seen_q || core_irq_out);
   end
   AST_CORE_OE: assert property ($past(rst_n_in) |->
      core_timer_expiry_pin_oe_out == $past(core_pin_en_in))
      else $error("expiry pin enable does not follow its control");
   AST_CORE_PULSE: assert property (
      core_irq_out && core_period_in != CNT_ZERO |=> !core_irq_out)
      else $error("core interrupt longer than one cycle");
   AST_CORE_GAP: assert property (core_irq_out && seen_q &&
      $stable(core_period_in) |-> gap_q == core_period_in + CNT_ONE)
      else $error("core interrupt spacing wrong");
   AST_GPT_STATUS: assert property ($past(rst_n_in) |->
      gpt_status_out == $past(gpt_enable_in))
      else $error("timer status does not follow enables");
   AST_GPT_CLEAR: assert property ($past(rst_n_in) &&
      !$past(gpt_status_out[0]) |-> gpt_count_out[31:0] == CNT_ZERO)
      else $error("disabled timer count not cleared");
   AST_GPT_OE: assert property (gpt_pin_oe_out[0] |->
      $past(gpt_config_in[1:0]) == DTSET_MODE_PWM)
      else $error("timer pin driven outside waveform mode");
   AST_GPT_PULSE: assert property (gpt_irq_out[0] &&
      gpt_period_in[31:0] > CNT_ONE |=> !gpt_irq_out[0])
      else $error("timer interrupt longer than one cycle");
   AST_PWM_PIN: assert property (gpt_pin_oe_out[0] && gpt_status_out[0]
      && $past(gpt_status_out[0]) && $stable(gpt_width_in[31:0])
      |-> gpt_pin_out[0] == ((gpt_count_out[31:0] < gpt_width_in[31:0])
      ~^ gpt_config_in[2]))
      else $error("waveform pin level wrong for count");
endmodule : dtset_top_properties
bind dtset_top dtset_top_properties #(.NUM_GPT(NUM_GPT))
   dtset_top_properties_inst (.ref_clk_in, .rst_n_in, .core_pin_en_in,
   .core_period_in, .gpt_enable_in, .gpt_config_in, .gpt_period_in,
   .gpt_width_in, .core_irq_out, .core_timer_expiry_pin_oe_out,
   .gpt_count_out, .gpt_status_out, .gpt_pin_out, .gpt_pin_oe_out,
   .gpt_irq_out);
`default_nettype wire

// file: verif/dtset_pin_model.sv
// External pin source: square wave, pull-up when idle
`timescale 1ns/1ps
`default_nettype none
module dtset_pin_model (
   input  wire logic       ref_clk_in,
   input  wire logic       run_in,
   input  wire logic [3:0] hi_len_in,
   input  wire logic [3:0] lo_len_in,
   input  wire logic [2:0] pin_out_in,
   input  wire logic [2:0] pin_oe_in,
   output logic      [2:0] pin_in_out
);
   logic       level_q = 1'b1;
   logic [3:0] cnt_q   = 4'h0;
   always @(posedge ref_clk_in) begin
      if (run_in && cnt_q + 4'h1 < (level_q ? hi_len_in : lo_len_in)) begin
         cnt_q <= cnt_q + 4'h1;
      end else begin
         cnt_q   <= 4'h0;
         level_q <= run_in ? !level_q : 1'b1;
      end
   end
   // Timer drives its pin; else source or pull-up wins
   assign pin_in_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & {3{level_q}});
endmodule : dtset_pin_model
`default_nettype wire

// file: verif/dtset_top_tb.sv
// Self-checking bench for the timer set
`timescale 1ns/1ps
`default_nettype none
module dtset_top_tb;
   import dtset_pkg::*;
   logic        ref_clk_in = 1'b0, rst_n_in = 1'b0, run = 1'b0;
   logic        core_enable_in = 1'b0, core_pin_en_in = 1'b0, pol;
   logic [31:0] core_period_in = 32'h0, core_count_out;
   logic [2:0]  gpt_enable_in = 3'h0, gpt_pin_in, gpt_status_out;
   logic [2:0]  gpt_overflow_out, gpt_pin_out, gpt_pin_oe_out, gpt_irq_out;
   logic [17:0] gpt_config_in = 18'h0;
   logic [95:0] gpt_period_in = 96'h0, gpt_width_in = 96'h0;
   logic [95:0] gpt_count_out, gpt_cap_period_out, gpt_cap_width_out;
   logic        core_irq_out, core_timer_expiry_pin_out;
   logic        core_timer_expiry_pin_oe_out;
   logic [3:0]  hi_len = 4'h3, lo_len = 4'h3;
   int          n_errors = 0, comparisons = 0, seed = 8149;
   int          g, per, wid, cyc, act;
   always #2.5 ref_clk_in = ~ref_clk_in;
   dtset_top dtset_top_inst (.ref_clk_in, .rst_n_in, .core_enable_in,
      .core_pin_en_in, .core_period_in, .gpt_enable_in, .gpt_config_in,
      .gpt_period_in, .gpt_width_in, .gpt_pin_in, .core_count_out,
      .core_irq_out, .core_timer_expiry_pin_out,
      .core_timer_expiry_pin_oe_out, .gpt_count_out, .gpt_cap_period_out,
      .gpt_cap_width_out, .gpt_status_out, .gpt_overflow_out,
      .gpt_pin_out, .gpt_pin_oe_out, .gpt_irq_out);
   dtset_pin_model dtset_pin_model_inst (.ref_clk_in, .run_in(run),
      .hi_len_in(hi_len), .lo_len_in(lo_len), .pin_out_in(gpt_pin_out),
      .pin_oe_in(gpt_pin_oe_out), .pin_in_out(gpt_pin_in));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask : tick
   // Counts cycles to the next interrupt and cycles at level pl
   task automatic wait_irq(input int idx, input logic pl, output int c,
                           output int a);
      logic [3:0] iv;
      logic [3:0] pv;
      c = 0;
      a = 0;
      do begin
         tick(1);
         c++;
         iv = {core_irq_out, gpt_irq_out};
         pv = {core_timer_expiry_pin_out, gpt_pin_out};
         if (pv[idx] === pl) a++;
      end while (iv[idx] !== 1'b1 && c < 300);
      if (c >= 300) begin
         n_errors++;
         conclude();
      end
   endtask : wait_irq
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude
   initial begin
      tick(20);
      check({gpt_irq_out, gpt_pin_oe_out, gpt_status_out}, 32'h0);
      @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      per = 2 + {$random(seed)} % 8;
      core_period_in <= per;
      core_pin_en_in <= 1'b1;
      core_enable_in <= 1'b1;
      wait_irq(3, 1'b1, cyc, act);
      wait_irq(3, 1'b1, cyc, act);
      check(cyc, per + 1);
      check(core_count_out, per);
      check(act, 1);
      check(core_timer_expiry_pin_oe_out, 1'b1);
      $display("core timer test done");
      for (g = 0; g < 3; g++) begin
         @(posedge ref_clk_in);
         per = 3 + {$random(seed)} % 8;
         wid = (g == 2) ? per - 1 : 1 + {$random(seed)} % (per - 1);
         pol = $random(seed);
         gpt_period_in[g*32 +: 32] <= per;
         gpt_width_in[g*32 +: 32] <= wid;
         gpt_config_in[g*6 +: 6] <= {2'h0, 1'h1, pol, DTSET_MODE_PWM};
         gpt_enable_in <= 3'h1 << g;
         wait_irq(g, pol, cyc, act);
         wait_irq(g, pol, cyc, act);
         check(cyc, per);
         check(act, wid);
         check(gpt_pin_oe_out[g], 1'b1);
         check(gpt_status_out, 3'h1 << g);
         @(posedge ref_clk_in);
         gpt_enable_in <= 3'h0;
         tick(3);
         check(gpt_count_out[g*32 +: 32], CNT_ZERO);
         $display("waveform test on timer %0d done", g);
      end
      @(posedge ref_clk_in);
      per = 2 + {$random(seed)} % 5;
      gpt_period_in[63:32] <= per;
      gpt_config_in[11:6] <= {2'h0, 1'h1, 1'h1, DTSET_MODE_WDOG};
      gpt_enable_in <= 3'h2;
      run <= 1'b1;
      wait_irq(1, 1'b1, cyc, act);
      // Count restarts on the edge that reaches the period
      check(gpt_count_out[63:32], CNT_ZERO);
      $display("watchdog test done");
      @(posedge ref_clk_in);
      run <= 1'b0;
      per = 2 + {$random(seed)} % 6;
      wid = 2 + {$random(seed)} % 6;
      hi_len <= 4'(wid);
      lo_len <= 4'(per);
      gpt_config_in[17:12] <= {2'h0, 1'h1, 1'h1, DTSET_MODE_WDTH};
      gpt_enable_in <= 3'h4;
      @(posedge ref_clk_in);
      run <= 1'b1;
      tick(60);
      check(gpt_cap_period_out[95:64], per + wid);
      check(gpt_cap_width_out[95:64], wid);
      check(gpt_pin_oe_out[2], 1'b0);
      check(gpt_overflow_out, 3'h0);
      $display("capture test done");
      conclude();
   end
endmodule : dtset_top_tb
`default_nettype wire
